// ---- rtl/fds_pkg.sv ----
// Shared widths, encodings and steering constants for the divider block.
package fds_pkg;
	localparam int N_DIV     = 4;
	localparam int N_STAGE   = 4;
	localparam int INT_W     = 8;
	localparam int FRAC_W    = 43;
	localparam int RATIO_W   = INT_W + FRAC_W;
	localparam int DIVIDE_W  = 32;
	localparam int PS_W      = 32;
	localparam int STEP_W    = 6;

	// Index of each steerable divider inside the divider arrays.
	localparam int DIV_FOUR  = 0;
	localparam int DIV_FIVE  = 1;
	localparam int DIV_SIX   = 2;
	localparam int DIV_SEVEN = 3;

	// Paths per output stage: every stage on this device is single.
	localparam int STAGE_PATHS = 1;

	// Period of one analog PLL cycle in femtoseconds, a plain default.
	localparam longint ANALOG_PLL_PERIOD_FS = 64'd73000;
	localparam longint FS_PER_PS            = 64'd1000;

	// Fraction units that lengthen one divider period by one picosecond.
	localparam longint FRAC_PER_PS =
		((64'd1 << FRAC_W) * FS_PER_PS) / ANALOG_PLL_PERIOD_FS;

	// Phase moved per divider period at each steering rate, in picoseconds.
	localparam logic [STEP_W-1:0] STEP_FAST_PS   = 6'h10;
	localparam logic [STEP_W-1:0] STEP_MEDIUM_PS = 6'h04;
	localparam logic [STEP_W-1:0] STEP_SLOW_PS   = 6'h01;

	typedef enum logic [1:0] {
		FDS_RATE_SLOW,
		FDS_RATE_MEDIUM,
		FDS_RATE_FAST
	} fds_rate_e;

	typedef logic [RATIO_W-1:0] fds_ratio_t;
endpackage : fds_pkg

// ---- rtl/fds_stage_if.sv ----
// Connection between the divider core and one output stage.
interface fds_stage_if #(
	parameter int PATHS = 1
);
	logic                  tick;
	logic [31:0]           divide_value;
	logic [31:0]           high_width;
	logic                  invert;
	logic [PATHS-1:0]      true_q;
	logic [PATHS-1:0]      comp_q;

	modport core (
		output tick,
		output divide_value,
		output high_width,
		output invert,
		input  true_q,
		input  comp_q
	);

	modport stage (
		input  tick,
		input  divide_value,
		input  high_width,
		input  invert,
		output true_q,
		output comp_q
	);
endinterface : fds_stage_if

// ---- rtl/fds_out_stage.sv ----
// Output stage: integer divide and high-width pulse shaping per path.
module fds_out_stage #(
	parameter int PATHS = 1
) (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	fds_stage_if.stage sif
);
	import fds_pkg::*;

	typedef struct packed {
		logic [PATHS-1:0][31:0] cnt;
		logic [PATHS-1:0]       q;
		logic [PATHS-1:0]       nq;
	} fds_stage_s;

	fds_stage_s st_r;
	fds_stage_s st_nxt;

	logic [31:0] half_w;
	logic [31:0] high_w;

	always_comb
	begin
		st_nxt = st_r;
		// Default waveform is high for half the period, rounded up for odd divide values.
		// The sum is one bit wider so the largest divide value does not wrap to zero.
		half_w = 32'(({1'b0, sif.divide_value} + 33'h000000001) >> 1);
		// Zero width keeps the default half split; otherwise the count sets the high time.
		high_w = (sif.high_width == 32'h00000000) ? half_w : sif.high_width;
		// Both copies of a dual stage run identical logic from one divider.
		for (int p = 0; p < PATHS; p++)
		begin
			if (sif.tick)
			begin
				// Counter wraps at the integer divide value.
				if (st_r.cnt[p] + 32'h00000001 >= sif.divide_value)
				begin
					st_nxt.cnt[p] = 32'h00000000;
				end
				else
				begin
					st_nxt.cnt[p] = st_r.cnt[p] + 32'h00000001;
				end
				// Pulse is always high-going; low elsewhere in every mode.
				st_nxt.q[p]  = (st_nxt.cnt[p] < high_w);
				// Complement pin inverts when its option is set.
				st_nxt.nq[p] = sif.invert ? ~st_nxt.q[p] : st_nxt.q[p];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign sif.true_q = st_r.q;
	assign sif.comp_q = st_r.nq;
endmodule : fds_out_stage

// ---- rtl/fds_top.sv ----
// Steerable fractional dividers feeding four output stages.
module fds_top (
	input  wire logic                                      ref_clk,
	input  wire logic                                      reset_n,
	input  wire logic [fds_pkg::N_DIV-1:0][fds_pkg::INT_W-1:0]  div_int,
	input  wire logic [fds_pkg::N_DIV-1:0][fds_pkg::FRAC_W-1:0] div_frac,
	input  wire logic [fds_pkg::N_DIV-1:0]                 fine_adjust_wr,
	input  wire logic [fds_pkg::N_DIV-1:0][fds_pkg::PS_W-1:0]   fine_adjust_ps,
	input  wire fds_pkg::fds_rate_e [fds_pkg::N_DIV-1:0]    steer_rate,
	input  wire logic                                      stage4_source_select,
	input  wire logic                                      stage7_source_select,
	input  wire logic [fds_pkg::N_STAGE-1:0][31:0]         output_integer_divide,
	input  wire logic [fds_pkg::N_STAGE-1:0][31:0]         output_high_pulse_width,
	input  wire logic [fds_pkg::N_STAGE-1:0]               complement_invert,
	output logic [fds_pkg::N_STAGE-1:0]                    true_output_pin,
	output logic [fds_pkg::N_STAGE-1:0]                    complement_output_pin,
	output logic [fds_pkg::N_DIV-1:0]                      phase_loop_feedback_tick,
	output logic [fds_pkg::N_DIV-1:0]                      steer_busy
);
	import fds_pkg::*;

	typedef struct packed {
		logic [INT_W-1:0]       cnt;
		logic [FRAC_W-1:0]      acc;
		logic signed [PS_W-1:0] rem;
		logic                   tick;
	} fds_div_s;

	typedef struct packed {
		fds_div_s [N_DIV-1:0] div;
		logic [N_DIV-1:0]     busy;
	} fds_top_s;

	localparam fds_ratio_t FRAC_PER_PS_R = fds_ratio_t'(FRAC_PER_PS);

	fds_top_s st_r;
	fds_top_s st_nxt;

	// Per-divider working values for the combinational step.
	logic [N_DIV-1:0][STEP_W-1:0] lvl_ps;
	logic [N_DIV-1:0][STEP_W-1:0] step_ps;
	logic [N_DIV-1:0][PS_W-1:0]   rem_mag;
	logic [N_DIV-1:0]             steering;
	logic [N_DIV-1:0][RATIO_W-1:0] delta;
	logic [N_DIV-1:0][RATIO_W-1:0] eff;
	logic [N_DIV-1:0][FRAC_W:0]   frac_sum;
	logic [N_DIV-1:0][INT_W-1:0]  period;
	logic signed [N_DIV-1:0][PS_W-1:0] consumed;

	always_comb
	begin
		st_nxt = st_r;
		for (int d = 0; d < N_DIV; d++)
		begin
			unique case (steer_rate[d])
				FDS_RATE_FAST:   lvl_ps[d] = STEP_FAST_PS;
				FDS_RATE_MEDIUM: lvl_ps[d] = STEP_MEDIUM_PS;
				FDS_RATE_SLOW:   lvl_ps[d] = STEP_SLOW_PS;
				default:         lvl_ps[d] = STEP_SLOW_PS;
			endcase
			steering[d] = (st_r.div[d].rem != '0);
			rem_mag[d]  = st_r.div[d].rem[PS_W-1] ? (~st_r.div[d].rem + 32'h00000001)
				: st_r.div[d].rem;
			// Full rate steps while enough phase remains, then the whole remainder in one final step.
			if (!steering[d])
			begin
				step_ps[d] = '0;
			end
			else if (rem_mag[d] >= PS_W'(lvl_ps[d]))
			begin
				step_ps[d] = lvl_ps[d];
			end
			else
			begin
				step_ps[d] = rem_mag[d][STEP_W-1:0];
			end
			delta[d] = RATIO_W'(step_ps[d] * FRAC_PER_PS_R);
			// Delay lengthens the period, advance shortens it; zero offset is nominal.
			if (st_r.div[d].rem[PS_W-1])
			begin
				eff[d]      = {div_int[d], div_frac[d]} - delta[d];
				consumed[d] = -$signed(PS_W'(step_ps[d]));
			end
			else
			begin
				eff[d]      = {div_int[d], div_frac[d]} + delta[d];
				consumed[d] = $signed(PS_W'(step_ps[d]));
			end
			// Fraction accumulator adds one extra input cycle on each carry.
			frac_sum[d] = {1'b0, st_r.div[d].acc} + {1'b0, eff[d][FRAC_W-1:0]};
			period[d]   = eff[d][RATIO_W-1:FRAC_W] + INT_W'(frac_sum[d][FRAC_W]);
			st_nxt.div[d].tick = 1'b0;
			if (st_r.div[d].cnt <= 8'h01)
			begin
				st_nxt.div[d].tick = 1'b1;
				st_nxt.div[d].acc  = frac_sum[d][FRAC_W-1:0];
				st_nxt.div[d].cnt  = (period[d] == '0) ? 8'h01 : period[d];
				st_nxt.div[d].rem  = st_r.div[d].rem - consumed[d];
			end
			else
			begin
				st_nxt.div[d].cnt = st_r.div[d].cnt - 8'h01;
			end
			// New requests add to whatever phase is still outstanding.
			if (fine_adjust_wr[d])
			begin
				st_nxt.div[d].rem = st_nxt.div[d].rem + $signed(fine_adjust_ps[d]);
			end
			st_nxt.busy[d] = (st_nxt.div[d].rem != '0);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Divider ticks reach the phase-loop feedback as registered pulses.
	always_comb
	begin
		for (int d = 0; d < N_DIV; d++)
		begin
			phase_loop_feedback_tick[d] = st_r.div[d].tick;
		end
	end
	assign steer_busy = st_r.busy;

	// Source selection per stage; stages 5 and 6 have a single choice.
	logic [N_STAGE-1:0] stage_tick;
	always_comb
	begin
		stage_tick[0] = stage4_source_select ? st_r.div[DIV_FIVE].tick
			: st_r.div[DIV_FOUR].tick;
		stage_tick[1] = st_r.div[DIV_FIVE].tick;
		stage_tick[2] = st_r.div[DIV_SIX].tick;
		stage_tick[3] = stage7_source_select ? st_r.div[DIV_SEVEN].tick
			: st_r.div[DIV_SIX].tick;
	end

	genvar g;
	generate
		for (g = 0; g < N_STAGE; g++)
		begin : g_stage
			fds_stage_if #(.PATHS(STAGE_PATHS)) sif ();

			assign sif.tick       = stage_tick[g];
			assign sif.divide_value = output_integer_divide[g];
			assign sif.high_width = output_high_pulse_width[g];
			assign sif.invert     = complement_invert[g];

			fds_out_stage #(
				.PATHS (STAGE_PATHS)
			) u_stage (
				.ref_clk (ref_clk),
				.reset_n (reset_n),
				.sif     (sif.stage)
			);

			assign true_output_pin[g]       = sif.true_q[0];
			assign complement_output_pin[g] = sif.comp_q[0];
		end
	endgenerate
endmodule : fds_top

// ---- test/fds_top_asserts.sv ----
// Port checks for the divider block.
module fds_top_asserts
	import fds_pkg::*;
(
	input wire logic                              ref_clk,
	input wire logic                              reset_n,
	input wire logic [N_DIV-1:0][INT_W-1:0]       div_int,
	input wire logic [N_DIV-1:0]                  fine_adjust_wr,
	input wire logic [N_DIV-1:0][PS_W-1:0]        fine_adjust_ps,
	input wire logic                              stage4_source_select,
	input wire logic                              stage7_source_select,
	input wire logic [N_STAGE-1:0]                complement_invert,
	input wire logic [N_STAGE-1:0]                true_output_pin,
	input wire logic [N_STAGE-1:0]                complement_output_pin,
	input wire logic [N_DIV-1:0]                  phase_loop_feedback_tick,
	input wire logic [N_DIV-1:0]                  steer_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_r;
	logic       seen_r;
	logic       quiet_r;
	wire  [3:0] tk = phase_loop_feedback_tick;
	// Period of divider four, and whether it was free of steering.
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n)
		begin
			cnt_r <= 8'h0;
			seen_r <= 1'b0;
			quiet_r <= 1'b0;
		end
		else
		begin
			cnt_r <= tk[0] ? 8'h0 : cnt_r + 8'h1;
			seen_r <= seen_r | tk[0];
			quiet_r <= tk[0] ? !steer_busy[0] : quiet_r;
		end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_tick_period: assert property (tk[0] && seen_r && quiet_r && !steer_busy[0] |->
		cnt_r + 8'h1 == div_int[0]) else $error("divider period wrong");
	a_tick_single: assert property ((tk & $past(tk)) == 4'h0)
		else $error("tick longer than one cycle");
	a_busy_rise: assert property (fine_adjust_wr[0] && fine_adjust_ps[0] != 32'h0
		&& !steer_busy[0] |=> steer_busy[0]) else $error("request not taken");
	a_busy_ends: assert property ($rose(steer_busy[0]) |-> ##[1:300] !steer_busy[0])
		else $error("steering never ends");
	a_stage4_src: assert property ($changed(true_output_pin[0]) |->
		$past(stage4_source_select ? tk[1] : tk[0])) else $error("stage4 source");
	a_stage5_src: assert property ($changed(true_output_pin[1]) |-> $past(tk[1]))
		else $error("stage5 source");
	a_stage6_src: assert property ($changed(true_output_pin[2]) |-> $past(tk[2]))
		else $error("stage6 source");
	a_stage7_src: assert property ($changed(true_output_pin[3]) |->
		$past(stage7_source_select ? tk[3] : tk[2])) else $error("stage7 source");
	a_comp_pin: assert property ($changed(true_output_pin[0]) && $stable(complement_invert[0])
		|-> complement_output_pin[0] == (true_output_pin[0] ^ complement_invert[0]))
		else $error("complement pin wrong");
	cover property (fine_adjust_wr[0] && steer_busy[0]);
	cover property (stage4_source_select && $changed(true_output_pin[0]));
	cover property (complement_invert[3] && $rose(true_output_pin[3]));
endmodule : fds_top_asserts

// ---- test/fds_pulse_meter.sv ----
// Clock receiver model: measures high time and period of one pin.
module fds_pulse_meter (
	input wire logic  ref_clk,
	input wire logic  pin,
	output logic [31:0] high_len,
	output logic [31:0] period
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] run_r = 32'h0;
	logic [31:0] hi_r = 32'h0;
	logic        last_r = 1'b0;
	initial high_len = 32'h0;
	initial period = 32'h0;
	always @(posedge ref_clk)
	begin
		if (pin && !last_r)
		begin
			period <= run_r;
			high_len <= hi_r;
			run_r <= 32'h1;
			hi_r <= 32'h1;
		end
		else
		begin
			run_r <= run_r + 32'h1;
			hi_r <= hi_r + {31'h0, pin};
		end
		last_r <= pin;
	end
endmodule : fds_pulse_meter

// ---- test/frac_divider_output_stage_bench.sv ----
// Self-checking bench for the divider block.
module frac_divider_output_stage_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import fds_pkg::*;
	logic ref_clk, reset_n, stage4_source_select, stage7_source_select;
	logic [N_DIV-1:0][INT_W-1:0] div_int;
	logic [N_DIV-1:0][FRAC_W-1:0] div_frac;
	logic [N_DIV-1:0] fine_adjust_wr, phase_loop_feedback_tick, steer_busy;
	logic [N_DIV-1:0][PS_W-1:0] fine_adjust_ps;
	fds_rate_e [N_DIV-1:0] steer_rate;
	logic [N_STAGE-1:0][31:0] output_integer_divide, output_high_pulse_width;
	logic [N_STAGE-1:0] complement_invert, true_output_pin, complement_output_pin;
	logic [7:0][31:0] hi, per;
	int fails = 0;
	int cmp_count = 0;
	fds_top i_fds_top (.ref_clk, .reset_n, .div_int, .div_frac, .fine_adjust_wr,
		.fine_adjust_ps, .steer_rate, .stage4_source_select, .stage7_source_select,
		.output_integer_divide, .output_high_pulse_width, .complement_invert,
		.true_output_pin, .complement_output_pin, .phase_loop_feedback_tick, .steer_busy);
	for (genvar g = 0; g < 8; g++)
	begin : g_meter
		fds_pulse_meter i_fds_pulse_meter (.ref_clk(ref_clk),
			.pin(g < 4 ? true_output_pin[g % 4] : complement_output_pin[g % 4]),
			.high_len(hi[g]), .period(per[g]));
	end
	always #5 ref_clk = ~ref_clk;
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk
	task automatic stage(input int s, input logic [31:0] p, h, c);
		chk("period", per[s], p);
		chk("high", hi[s], h);
		chk("comp high", hi[s+4], c);
	endtask : stage
	// Two requests on successive edges, then the busy span in cycles.
	task automatic steer(input fds_rate_e r, input logic [31:0] a, b, input int n);
		int cnt;
		cnt = 0;
		steer_rate[0] <= r;
		fine_adjust_ps[0] <= a;
		fine_adjust_wr[0] <= 1'b1;
		@(posedge ref_clk);
		fine_adjust_ps[0] <= b;
		@(posedge ref_clk);
		chk("busy", 32'(steer_busy[0]), 32'h1);
		fine_adjust_wr[0] <= 1'b0;
		while (steer_busy[0] && cnt < 400)
		begin
			@(posedge ref_clk);
			cnt++;
		end
		chk("span", 32'(cnt >= 13 * (n - 1) && cnt <= 15 * n + 2), 32'h1);
	endtask : steer
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	initial
	begin
		#100000;
		fails++;
		give_verdict();
	end
	initial
	begin
		ref_clk = 1'b0;
		reset_n = 1'b0;
		div_int = {4{8'h0E}};
		div_frac = '0;
		fine_adjust_wr = 4'h0;
		fine_adjust_ps = '0;
		foreach (steer_rate[i])
			steer_rate[i] = FDS_RATE_SLOW;
		stage4_source_select = 1'b0;
		stage7_source_select = 1'b0;
		output_integer_divide = {32'h7, 32'h5, 32'h5, 32'h4};
		output_high_pulse_width = {32'h3, 32'h0, 32'h1, 32'h0};
		complement_invert = 4'hC;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (400) @(posedge ref_clk);
		stage(0, 32'h38, 32'h1C, 32'h1C);
		stage(1, 32'h46, 32'h0E, 32'h0E);
		stage(2, 32'h46, 32'h2A, 32'h1C);
		stage(3, 32'h62, 32'h2A, 32'h38);
		div_int[1] <= 8'h14;
		div_int[3] <= 8'h10;
		div_frac[2] <= 43'h200_0000_0000;
		stage4_source_select <= 1'b1;
		stage7_source_select <= 1'b1;
		output_integer_divide <= {32'h7, 32'h4, 32'h5, 32'h4};
		output_high_pulse_width <= {32'h0, 32'h0, 32'h2, 32'h0};
		complement_invert <= 4'h9;
		repeat (400) @(posedge ref_clk);
		stage(0, 32'h50, 32'h28, 32'h28);
		stage(1, 32'h64, 32'h28, 32'h28);
		stage(3, 32'h70, 32'h40, 32'h30);
		chk("frac period", per[2], 32'h39);
		chk("frac high", 32'(hi[2] > 32'h1B && hi[2] < 32'h1E), 32'h1);
		steer(FDS_RATE_FAST, 32'h10, 32'h0, 1);
		steer(FDS_RATE_MEDIUM, 32'hFFFF_FFF0, 32'h0, 4);
		steer(FDS_RATE_SLOW, 32'h8, 32'h8, 16);
		steer(FDS_RATE_MEDIUM, 32'h10, 32'hFFFF_FFF8, 2);
		give_verdict();
	end
endmodule : frac_divider_output_stage_bench
bind fds_top fds_top_asserts i_fds_top_asserts (.ref_clk, .reset_n, .div_int,
	.fine_adjust_wr, .fine_adjust_ps, .stage4_source_select, .stage7_source_select,
	.complement_invert, .true_output_pin, .complement_output_pin,
	.phase_loop_feedback_tick, .steer_busy);
